// file: verilog/iprf_map.svh
// Constants of the interleaved parity repair framer
// Behaviour
// - Protection arithmetic is bitwise XOR
// - Repair RTP version field is 2
// - Padding bit XORed, never append padding
// - Extension bit XORed, never emit extension
// - Source count XORed, never emit source list
// - Marker bit is XOR of markers
// - Repair payload type dynamic, unknown discarded
// - Repair sequence steps by one, random start
// - Repair timestamp is transmission time
// - Random source identifier, shared name, collisions resolved
// - Payload protects the first DEPTH bytes after fixed header
// - FEC header is 16 octets after RTP
// - Base sequence is lowest, wrap aware
// - Recovery fields restore length, type, timestamp
// - Extension flag set, second flag reserved
// - Mask, row flag, index, upper base unused
// - Column and row counts carried in header
// - Code type names the parity code
// - Columns and rows within 1 to 255; code also caps columns at MAX_COLS
// - Timestamp rate above 1000 Hz
// - Source packets pass unmodified, sequence identified
`ifndef IPRF_MAP_SVH
`define IPRF_MAP_SVH
// ==================================================
// Packet layout
`define IPRF_RTP_HDR_BYTES  16'h000C
`define IPRF_CAPT_BYTES     16'h0008
`define IPRF_REP_HDR_LAST   16'h001B
`define IPRF_RTP_VERSION    2'h2
`define IPRF_EXT_FLAG       1'h1
`define IPRF_RSV_FLAG       1'h0
`define IPRF_CODE_PARITY    3'h0
`define IPRF_DYN_PT_MIN     7'h60
`define IPRF_BYTE_W         8
`endif

// file: verilog/iprf_pkg.sv
// Types of the interleaved parity repair framer
package iprf_pkg;
    typedef logic [7:0] iprf_byte_t;

    typedef enum logic [1:0] {
        ST_PASS,
        ST_LOAD,
        ST_HDR,
        ST_PAY
    } iprf_state_e;

    typedef struct packed {
        logic [1:0]  ver;
        logic        pad;
        logic        ext;
        logic [3:0]  cnt;
        logic        mark;
        logic [6:0]  ptype;
        logic [15:0] seq;
        logic [31:0] ts;
    } iprf_rtp_s;

    typedef struct packed {
        logic        pad;
        logic        ext;
        logic [3:0]  cnt;
        logic        mark;
        logic [6:0]  ptype;
        logic [31:0] ts;
        logic [15:0] lenx;
        logic [15:0] lenmax;
        logic [15:0] base;
    } iprf_col_s;

    typedef struct packed {
        logic [1:0]  ver;
        logic        pad;
        logic        ext;
        logic [3:0]  cnt;
        logic        mark;
        logic [6:0]  ptype;
        logic [15:0] seq;
        logic [31:0] ts;
        logic [31:0] ssrc;
        logic [15:0] base;
        logic [15:0] len_rec;
        logic        eflag;
        logic [6:0]  pt_rec;
        logic [23:0] mask;
        logic [31:0] ts_rec;
        logic        nflag;
        logic        rowflag;
        logic [2:0]  ctype;
        logic [2:0]  index;
        logic [7:0]  cols;
        logic [7:0]  rows;
        logic [7:0]  base_hi;
    } iprf_rep_hdr_s;
endpackage : iprf_pkg

// file: verilog/iprf_store_if.sv
// Carrier between framer and column store
`timescale 1ns/1ps
interface iprf_store_if #(
    parameter int COL_W  = 3,
    parameter int ADDR_W = 8
);
    logic              wr_en;
    logic              wr_fresh;
    logic [COL_W-1:0]  wr_col;
    logic [ADDR_W-1:0] wr_addr;
    logic [7:0]        wr_data;
    logic [COL_W-1:0]  rd_col;
    logic [ADDR_W-1:0] rd_addr;
    logic [7:0]        rd_data;

    modport framer (
        output wr_en, wr_fresh, wr_col, wr_addr, wr_data, rd_col, rd_addr,
        input  rd_data
    );
    modport store (
        input  wr_en, wr_fresh, wr_col, wr_addr, wr_data, rd_col, rd_addr,
        output rd_data
    );
endinterface : iprf_store_if

// file: verilog/iprf_col_store.sv
// Per-column repair payload accumulator
`timescale 1ns/1ps
module iprf_col_store #(
    parameter int MAX_COLS = 8,
    parameter int DEPTH    = 256
) (
    input  wire logic   clk_i,
    iprf_store_if.store st
);
    import iprf_pkg::*;

    iprf_byte_t mem [MAX_COLS][DEPTH];

    // ==================================================
    // Accumulate
    always_ff @(posedge clk_i) begin
        if (st.wr_en) begin
            if (st.wr_fresh) begin
                mem[st.wr_col][st.wr_addr] <= st.wr_data;
            end else begin
                mem[st.wr_col][st.wr_addr] <= mem[st.wr_col][st.wr_addr] ^ st.wr_data;
            end
        end
    end

    assign st.rd_data = mem[st.rd_col][st.rd_addr];
endmodule : iprf_col_store

// file: verilog/iprf_framer.sv
// Interleaved parity repair packet framer
`timescale 1ns/1ps
`include "iprf_map.svh"
module iprf_framer #(
    parameter int MAX_COLS = 8,
    parameter int DEPTH    = 256
) (
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    input  wire logic [7:0]         cols_i,
    input  wire logic [7:0]         rows_i,
    input  wire logic [6:0]         pt_i,
    input  wire logic [31:0]        ssrc_i,
    input  wire logic [15:0]        seq_seed_i,
    input  wire logic [31:0]        ts_now_i,
    input  wire logic               src_valid_i,
    input  wire iprf_pkg::iprf_byte_t src_data_i,
    input  wire logic               src_last_i,
    output logic                    src_ready_o,
    output logic                    out_valid_o,
    output iprf_pkg::iprf_byte_t    out_data_o,
    output logic                    out_last_o,
    output logic                    out_repair_o,
    output logic                    cfg_err_o
);
    import iprf_pkg::*;

    localparam int COL_W  = (MAX_COLS > 1) ? $clog2(MAX_COLS) : 1;
    localparam int ADDR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [15:0] DEPTH_W = 16'(DEPTH);
    localparam logic [8:0]  COLS_W  = 9'(MAX_COLS);

    iprf_store_if #(.COL_W(COL_W), .ADDR_W(ADDR_W)) st_if ();

    iprf_col_store #(
        .MAX_COLS(MAX_COLS),
        .DEPTH   (DEPTH)
    ) u_store (
        .clk_i(clk_i),
        .st   (st_if.store)
    );

    iprf_state_e   st_q;
    iprf_state_e   st_d;
    logic          ready_q;
    logic          out_valid_q;
    iprf_byte_t    out_data_q;
    logic          out_last_q;
    logic          out_repair_q;
    logic          cfg_err_q;
    logic          cfg_bad;
    logic [15:0]   bcnt_q;
    logic [63:0]   capt_q;
    logic [7:0]    col_q;
    logic [7:0]    row_q;
    logic [7:0]    ecol_q;
    logic [15:0]   ecnt_q;
    logic [15:0]   seq_q;
    logic          seeded_q;
    logic [223:0]  hdr_q;
    iprf_col_s     col_st_q [MAX_COLS];
    iprf_col_s     cur;
    iprf_col_s     wcur;
    iprf_rtp_s     rh;
    iprf_rep_hdr_s rep;
    logic          acc;
    logic          pkt_end;
    logic          blk_end;
    logic          col_done;
    logic          last_col;
    logic [15:0]   paddr;
    logic [15:0]   plen;
    logic [15:0]   plen_c;

    // ==================================================
    // Input accept and header capture
    assign acc     = src_valid_i && ready_q;
    assign pkt_end = acc && src_last_i;
    assign rh      = iprf_rtp_s'(capt_q);
    assign paddr   = 16'(bcnt_q - `IPRF_RTP_HDR_BYTES);
    assign plen    = 16'(paddr + 16'h0001);
    assign plen_c  = (plen > DEPTH_W) ? DEPTH_W : plen;
    assign blk_end = pkt_end && (col_q == 8'(cols_i - 8'h01)) && (row_q == 8'(rows_i - 8'h01));
    assign cur     = col_st_q[ecol_q[COL_W-1:0]];
    assign wcur    = col_st_q[col_q[COL_W-1:0]];
    assign last_col = (ecol_q == 8'(cols_i - 8'h01));

    assign cfg_bad = (cols_i == 8'h00) || (rows_i == 8'h00)
                  || ({1'b0, cols_i} > COLS_W)
                  || (pt_i < `IPRF_DYN_PT_MIN);

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            bcnt_q <= 16'h0000;
        end else if (acc) begin
            bcnt_q <= src_last_i ? 16'h0000 : 16'(bcnt_q + 16'h0001);
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            capt_q <= 64'h0;
        end else if (acc && bcnt_q < `IPRF_CAPT_BYTES) begin
            capt_q <= {capt_q[55:0], src_data_i};
        end
    end

    // ==================================================
    // Block position by arrival order
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            col_q <= 8'h00;
            row_q <= 8'h00;
        end else if (pkt_end) begin
            if (col_q == 8'(cols_i - 8'h01)) begin
                col_q <= 8'h00;
                row_q <= blk_end ? 8'h00 : 8'(row_q + 8'h01);
            end else begin
                col_q <= 8'(col_q + 8'h01);
            end
        end
    end

    // ==================================================
    // Protected bytes into column store
    assign st_if.wr_en    = acc && (bcnt_q >= `IPRF_RTP_HDR_BYTES) && (paddr < DEPTH_W);
    assign st_if.wr_fresh = (row_q == 8'h00) || (paddr >= wcur.lenmax);
    assign st_if.wr_col   = col_q[COL_W-1:0];
    assign st_if.wr_addr  = paddr[ADDR_W-1:0];
    assign st_if.wr_data  = src_data_i;
    assign st_if.rd_col   = ecol_q[COL_W-1:0];
    assign st_if.rd_addr  = ecnt_q[ADDR_W-1:0];

    // ==================================================
    // Per-column header protection
    for (genvar g = 0; g < MAX_COLS; g++) begin : g_col
        always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
                col_st_q[g] <= '0;
            end else if (pkt_end && col_q == 8'(g)) begin
                if (row_q == 8'h00) begin
                    col_st_q[g].pad    <= rh.pad;
                    col_st_q[g].ext    <= rh.ext;
                    col_st_q[g].cnt    <= rh.cnt;
                    col_st_q[g].mark   <= rh.mark;
                    col_st_q[g].ptype  <= rh.ptype;
                    col_st_q[g].ts     <= rh.ts;
                    col_st_q[g].lenx   <= plen;
                    col_st_q[g].lenmax <= plen_c;
                    col_st_q[g].base   <= rh.seq;
                end else begin
                    col_st_q[g].pad   <= col_st_q[g].pad ^ rh.pad;
                    col_st_q[g].ext   <= col_st_q[g].ext ^ rh.ext;
                    col_st_q[g].cnt   <= col_st_q[g].cnt ^ rh.cnt;
                    col_st_q[g].mark  <= col_st_q[g].mark ^ rh.mark;
                    col_st_q[g].ptype <= col_st_q[g].ptype ^ rh.ptype;
                    col_st_q[g].ts    <= col_st_q[g].ts ^ rh.ts;
                    col_st_q[g].lenx  <= col_st_q[g].lenx ^ plen;
                    if (plen_c > col_st_q[g].lenmax) begin
                        col_st_q[g].lenmax <= plen_c;
                    end
                    if ($signed(16'(rh.seq - col_st_q[g].base)) < $signed(16'h0000)) begin
                        col_st_q[g].base <= rh.seq;
                    end
                end
            end
        end
    end

    // ==================================================
    // Repair header build
    always_comb begin
        rep         = '0;
        rep.ver     = `IPRF_RTP_VERSION;
        rep.pad     = cur.pad;
        rep.ext     = cur.ext;
        rep.cnt     = cur.cnt;
        rep.mark    = cur.mark;
        rep.ptype   = pt_i;
        rep.seq     = seq_q;
        rep.ts      = ts_now_i;
        rep.ssrc    = ssrc_i;
        rep.base    = cur.base;
        rep.len_rec = cur.lenx;
        rep.eflag   = `IPRF_EXT_FLAG;
        rep.pt_rec  = cur.ptype;
        rep.ts_rec  = cur.ts;
        rep.nflag   = `IPRF_RSV_FLAG;
        rep.rowflag = `IPRF_RSV_FLAG;
        rep.ctype   = `IPRF_CODE_PARITY;
        rep.cols    = cols_i;
        rep.rows    = rows_i;
    end

    // ==================================================
    // Emission sequencing
    assign col_done = ((st_q == ST_HDR) && (ecnt_q == `IPRF_REP_HDR_LAST) && (cur.lenmax == 16'h0000))
                   || ((st_q == ST_PAY) && (ecnt_q == 16'(cur.lenmax - 16'h0001)));

    always_comb begin
        st_d = st_q;
        unique case (st_q)
            ST_PASS: begin
                if (blk_end) begin
                    st_d = ST_LOAD;
                end
            end
            ST_LOAD: begin
                st_d = ST_HDR;
            end
            ST_HDR: begin
                if (col_done) begin
                    st_d = last_col ? ST_PASS : ST_LOAD;
                end else if (ecnt_q == `IPRF_REP_HDR_LAST) begin
                    st_d = ST_PAY;
                end
            end
            ST_PAY: begin
                if (col_done) begin
                    st_d = last_col ? ST_PASS : ST_LOAD;
                end
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_q <= ST_PASS;
        end else begin
            st_q <= st_d;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ecnt_q <= 16'h0000;
        end else if (st_q == ST_LOAD || (st_q == ST_HDR && ecnt_q == `IPRF_REP_HDR_LAST)) begin
            ecnt_q <= 16'h0000;
        end else if (st_q == ST_HDR || st_q == ST_PAY) begin
            ecnt_q <= 16'(ecnt_q + 16'h0001);
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ecol_q <= 8'h00;
        end else if (st_q == ST_PASS) begin
            ecol_q <= 8'h00;
        end else if (col_done) begin
            ecol_q <= 8'(ecol_q + 8'h01);
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            hdr_q <= 224'h0;
        end else if (st_q == ST_LOAD) begin
            hdr_q <= rep;
        end else if (st_q == ST_HDR) begin
            hdr_q <= {hdr_q[215:0], 8'h00};
        end
    end

    // ==================================================
    // Sequence number, seeded after reset
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            seq_q    <= 16'h0000;
            seeded_q <= 1'b0;
        end else if (!seeded_q) begin
            seq_q    <= seq_seed_i;
            seeded_q <= 1'b1;
        end else if (col_done) begin
            seq_q <= 16'(seq_q + 16'h0001);
        end
    end

    // ==================================================
    // Output registers
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ready_q   <= 1'b0;
            cfg_err_q <= 1'b0;
        end else begin
            ready_q   <= (st_d == ST_PASS) && !cfg_bad && seeded_q;
            cfg_err_q <= cfg_bad;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            out_valid_q  <= 1'b0;
            out_data_q   <= 8'h00;
            out_last_q   <= 1'b0;
            out_repair_q <= 1'b0;
        end else begin
            out_valid_q  <= acc || st_q == ST_HDR || st_q == ST_PAY;
            out_repair_q <= st_q == ST_HDR || st_q == ST_PAY;
            out_last_q   <= acc ? src_last_i : col_done;
            if (st_q == ST_HDR) begin
                out_data_q <= hdr_q[223:216];
            end else if (st_q == ST_PAY) begin
                out_data_q <= st_if.rd_data;
            end else begin
                out_data_q <= src_data_i;
            end
        end
    end

    assign src_ready_o  = ready_q;
    assign out_valid_o  = out_valid_q;
    assign out_data_o   = out_data_q;
    assign out_last_o   = out_last_q;
    assign out_repair_o = out_repair_q;
    assign cfg_err_o    = cfg_err_q;

    // ==================================================
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_load;
        st_q == ST_LOAD;
    endsequence

    sequence s_hdr_end;
        st_q == ST_HDR && ecnt_q == `IPRF_REP_HDR_LAST;
    endsequence

    chk_fec_hdr_len: assert property (s_load |=> ##27 s_hdr_end)
        else $error("repair header not 28 bytes");

    chk_version_two: assert property (s_load |=> ##1 out_data_o[7:6] == `IPRF_RTP_VERSION)
        else $error("repair version wrong");

    chk_seq_step: assert property (seeded_q && $past(seeded_q) && seq_q != $past(seq_q)
                                   |-> seq_q == 16'($past(seq_q) + 16'h0001))
        else $error("repair sequence did not step by one");

    chk_seq_msb_first: assert property (st_q == ST_HDR && ecnt_q == 16'h0002
                                        |=> out_data_o == seq_q[15:8])
        else $error("sequence high byte not first");

    chk_src_passthru: assert property (acc |=> out_valid_o && !out_repair_o
                                       && out_data_o == $past(src_data_i))
        else $error("source byte altered");

    chk_no_trailer: assert property (st_q == ST_PAY && col_done |=> out_last_o && out_repair_o
                                     ##1 !out_repair_o || $past(st_q, 1) == ST_LOAD)
        else $error("repair packet ran past protected length");

    chk_cfg_block: assert property (cfg_bad |=> !src_ready_o)
        else $error("accepting with bad configuration");

    chk_fresh_row: assert property (st_if.wr_en && row_q == 8'h00 |-> st_if.wr_fresh)
        else $error("first row did not overwrite");

    chk_ready_emit: assert property (st_q != ST_PASS |-> !src_ready_o)
        else $error("source accepted during repair");

    chk_ext_flag: assert property (st_q == ST_HDR && ecnt_q == 16'h0010
                                   |=> out_data_o[7] == `IPRF_EXT_FLAG)
        else $error("extension flag not set");
endmodule : iprf_framer

// file: verification/iprf_rx_model.sv
// Receiver model that collects the framer output stream
`timescale 1ns/1ps
module iprf_rx_model (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic [6:0] known_pt_i,
    input  wire logic       valid_i,
    input  wire logic [7:0] data_i,
    input  wire logic       last_i,
    input  wire logic       repair_i
);
    logic [9:0] rx_q[$];
    int         discards;
    int         idx;
    // ==================================================
    // Capture, always ready to take a byte
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            idx = 0;
            discards = 0;
        end else if (valid_i === 1'b1) begin
            rx_q.push_back({repair_i, last_i, data_i});
            if (repair_i === 1'b1 && idx == 1 && data_i[6:0] !== known_pt_i) begin
                discards++;
            end
            idx = (last_i === 1'b1) ? 0 : idx + 1;
        end
    end
endmodule : iprf_rx_model

// file: verification/iprf_framer_tb.sv
// Testbench of the interleaved parity repair framer
`timescale 1ns/1ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin mismatches++; \
    $display("[ERR] t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
module interleaved_parity_repair_framer_test;
    import iprf_pkg::*;
    localparam int          COLS   = 2;
    localparam int          ROWS   = 2;
    localparam logic [6:0]  REP_PT = 7'h60;
    localparam logic [31:0] SSRC   = 32'h1234_5678;
    localparam logic [15:0] SEED   = 16'hFFFF;
    localparam logic [31:0] TS_NOW = 32'hA5A5_0F0F;
    logic        clk_i, rst_i, src_valid_i, src_last_i, src_ready_o;
    logic        out_valid_o, out_last_o, out_repair_o, cfg_err_o;
    logic [7:0]  cols_i, rows_i;
    logic [6:0]  pt_i;
    logic [31:0] ssrc_i, ts_now_i;
    logic [15:0] seq_seed_i, rep_seq;
    iprf_byte_t  src_data_i, out_data_o;
    logic [9:0]  exp_q[$];
    int          mismatches, compares;
    logic [7:0]  acc[COLS][256];
    logic [15:0] lenx[COLS], lenmax[COLS], base[COLS];
    logic [6:0]  ptx[COLS], hbx[COLS];
    logic [31:0] tsx[COLS];
    logic [22:0] cfg_tab[5] = '{{8'h00, 8'h02, 7'h60}, {8'h09, 8'h02, 7'h60}, {8'h02, 8'h00, 7'h60},
                                {8'h02, 8'h02, 7'h5F}, {8'h08, 8'hFF, 7'h7F}};

    iprf_framer #(.MAX_COLS(8), .DEPTH(256)) i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .cols_i(cols_i), .rows_i(rows_i), .pt_i(pt_i),
        .ssrc_i(ssrc_i), .seq_seed_i(seq_seed_i), .ts_now_i(ts_now_i), .src_valid_i(src_valid_i),
        .src_data_i(src_data_i), .src_last_i(src_last_i), .src_ready_o(src_ready_o),
        .out_valid_o(out_valid_o), .out_data_o(out_data_o), .out_last_o(out_last_o),
        .out_repair_o(out_repair_o), .cfg_err_o(cfg_err_o));
    iprf_rx_model i_rx (.clk_i(clk_i), .rst_i(rst_i), .known_pt_i(REP_PT), .valid_i(out_valid_o),
        .data_i(out_data_o), .last_i(out_last_o), .repair_i(out_repair_o));

    always #12.5 clk_i = ~clk_i;

    // ==================================================
    // Source byte handshake
    task automatic put_byte(input logic [7:0] b, input logic last);
        logic ok;
        int   n;
        n = 0;
        src_data_i = b;
        src_last_i = last;
        do begin
            @(negedge clk_i);
            ok = src_ready_o;
            @(posedge clk_i);
            n++;
        end while (ok !== 1'b1 && n < 2000);
        if (ok !== 1'b1) mismatches++;
        #1;
    endtask : put_byte

    task automatic send_pkt(input int k, input logic [15:0] seq, input int c, input int r);
        logic [95:0] hdr;
        logic [7:0]  b;
        int          n;
        n = 13 + (k * 5) % 7;
        hdr = {2'h2, k[0], k[1], k[5:2], k[2] ^ k[0], 7'(k + 3), seq, 32'h1000_0000 + 32'(k * 3),
               32'h0BAD_F00D};
        if (r == 0) begin
            for (int i = 0; i < 256; i++) acc[c][i] = 8'h00;
            {lenx[c], lenmax[c], ptx[c], hbx[c], tsx[c]} = '0;
            base[c] = seq;
        end
        hbx[c] ^= {k[0], k[1], k[5:2], k[2] ^ k[0]};
        ptx[c] ^= 7'(k + 3);
        tsx[c] ^= hdr[63:32];
        lenx[c] ^= 16'(n - 12);
        if (16'(n - 12) > lenmax[c]) lenmax[c] = 16'(n - 12);
        src_valid_i = 1'b1;
        for (int i = 0; i < n; i++) begin
            b = (i < 12) ? hdr[95 - 8 * i -: 8] : 8'(k * 37 + i * 11 + 8'h5A);
            if (i >= 12) acc[c][i - 12] ^= b;
            exp_q.push_back({1'b0, i == n - 1, b});
            put_byte(b, i == n - 1);
        end
        src_valid_i = 1'b0;
        src_last_i = 1'b0;
        @(posedge clk_i);
        #1;
    endtask : send_pkt

    // Expected repair packets, one per column
    task automatic push_repair();
        logic [223:0] h;
        for (int c = 0; c < COLS; c++) begin
            h = {2'h2, hbx[c], REP_PT, rep_seq, TS_NOW, SSRC, base[c], lenx[c], 1'b1, ptx[c],
                 24'h000000, tsx[c], 8'h00, 8'(COLS), 8'(ROWS), 8'h00};
            rep_seq++;
            for (int i = 0; i < 28; i++) exp_q.push_back({2'b10, h[223 - 8 * i -: 8]});
            for (int i = 0; i < lenmax[c]; i++) exp_q.push_back({1'b1, i == int'(lenmax[c]) - 1, acc[c][i]});
        end
    endtask : push_repair

    task automatic complete_run();
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : complete_run

    // ==================================================
    // Tests
    initial begin
        clk_i = 1'b0;
        rst_i = 1'b1;
        {cols_i, rows_i, pt_i} = {8'(COLS), 8'(ROWS), REP_PT};
        {ssrc_i, seq_seed_i, ts_now_i} = {SSRC, SEED, TS_NOW};
        {src_valid_i, src_data_i, src_last_i} = '0;
        mismatches = 0;
        compares = 0;
        rep_seq = SEED;
        repeat (2) @(posedge clk_i);
        #1;
        `CHK({src_ready_o, out_valid_o, out_last_o, out_repair_o, cfg_err_o}, 5'h00)
        rst_i = 1'b0;
        for (int blk = 0; blk < 2; blk++) begin
            for (int k = 0; k < COLS * ROWS; k++) begin
                send_pkt(blk * 4 + k, 16'hFFFE + 16'(blk * 4 + k), k % COLS, k / COLS);
            end
            push_repair();
        end
        for (int n = 0; n < 3000 && i_rx.rx_q.size() < exp_q.size(); n++) @(posedge clk_i);
        repeat (4) @(posedge clk_i);
        #1;
        `CHK(i_rx.rx_q.size(), exp_q.size())
        foreach (exp_q[i]) begin
            if (i < i_rx.rx_q.size()) begin
                if (exp_q[i][9:8] == 2'b10) begin
                    `CHK(i_rx.rx_q[i], exp_q[i])
                end else if (exp_q[i][9]) begin
                    `CHK(i_rx.rx_q[i], exp_q[i])
                end else begin
                    `CHK(i_rx.rx_q[i], exp_q[i])
                end
            end
        end
        `CHK(i_rx.discards, 0)
        foreach (cfg_tab[i]) begin
            {cols_i, rows_i, pt_i} = cfg_tab[i];
            repeat (4) @(posedge clk_i);
            #1;
            `CHK({cfg_err_o, src_ready_o}, {i < 4, i >= 4})
        end
        complete_run();
    end

    initial begin
        #400000;
        mismatches++;
        complete_run();
    end
endmodule : interleaved_parity_repair_framer_test
